// ===== logic/t1_rx_perf_pkg.sv
// constants and carriers for the receive performance monitor
package t1_rx_perf_pkg;
    // register offsets
    localparam logic [7:0] ADDR_LCV_HIGH   = 8'h50;
    localparam logic [7:0] ADDR_LCV_LOW    = 8'h51;
    localparam logic [7:0] ADDR_ERR_CFG    = 8'h86;
    localparam logic [7:0] ADDR_EVT_STATUS = 8'h96;
    localparam logic [7:0] ADDR_EVT_MASK   = 8'hA6;
    localparam logic [7:0] REG_RESET       = 8'h00;
    // event bit positions
    localparam int EVT_CODE_DET   = 0;
    localparam int EVT_CODE_CLR   = 1;
    localparam int EVT_LINK_FULL  = 2;
    localparam int EVT_FS_ALIGN   = 3;
    localparam int EVT_AIS_CI     = 4;
    localparam int EVT_REMOTE_CI  = 5;
    localparam int EVT_COUNT      = 6;
    // configuration bit positions
    localparam int CFG_EXCESS_ZERO  = 0;
    localparam int CFG_OOS_SELECT   = 1;
    localparam int CFG_FS_REPORT    = 2;
    localparam int CFG_ACCUM_MODE   = 3;
    localparam int CFG_INTERVAL     = 4;
    localparam int CFG_MANUAL_TRIG  = 5;
    localparam int CFG_MANUAL_SRC   = 6;
    localparam int CFG_SECOND_SRC   = 7;
    // timing
    localparam longint CLK_FREQ_HZ    = 50_000_000;
    localparam longint ONE_SECOND_MS  = 1000;
    localparam int SECOND_CYCLES =
        int'(CLK_FREQ_HZ * ONE_SECOND_MS / 1000);
    localparam longint MANUAL_WAIT_US = 250;
    localparam int MANUAL_WAIT_CYCLES =
        int'((CLK_FREQ_HZ * MANUAL_WAIT_US + 999_999) / 1_000_000);
    localparam int SHORT_T1_US = 42000;
    localparam int SHORT_E1_US = 62500;
    localparam logic [8:0] FRAMES_T1_SHORT = 9'd336;
    localparam logic [8:0] FRAMES_E1_SHORT = 9'd500;
    // excessive-zero run lengths
    localparam logic [4:0] ZERO_RUN_PLAIN = 5'd16;
    localparam logic [4:0] ZERO_RUN_B8ZS  = 5'd8;
    localparam logic [15:0] COUNT_MAX     = 16'hFFFF;
    localparam logic [2:0]  LINK_LAST_BIT = 3'h7;

    typedef enum logic {ACC_TIMED, ACC_MANUAL} accum_mode_t;

    // host parallel port request, one cycle per access
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wrData;
        logic       wrEn;
        logic       rdEn;
    } host_req_t;

    // detector results feeding the event flags
    typedef struct packed {
        logic remoteAlarmCi;
        logic remoteAlarmPresent;
        logic esfFraming;
        logic aisCi;
        logic aisPresent;
        logic fsAlignFound;
        logic linkBitValid;
        logic linkBit;
        logic codeValid;
    } detect_in_t;

    // receive line information for the line-code counter
    typedef struct packed {
        logic bitStrobe;
        logic rxZero;
        logic bipolarViolation;
        logic b8zsCodeword;
        logic b8zsEnable;
        logic frameTick;
        logic e1Mode;
        logic receiveSyncLost;
    } line_in_t;
endpackage : t1_rx_perf_pkg

// ===== logic/t1_rx_perf_monitor.sv
// per-port receive event flags, error-count latching and line-code counter
`timescale 1ns/10ps
`default_nettype none
module t1_rx_perf_monitor
    import t1_rx_perf_pkg::*;
#(
    parameter int SECOND_COUNT = SECOND_CYCLES
) (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       reset,
    // host parallel port
    input  wire host_req_t  hostReq,
    output logic [7:0]      rdData,
    // detectors and line
    input  wire detect_in_t detectIn,
    input  wire line_in_t   lineIn,
    // shared timing and global latch
    input  wire logic       firstPortSecond,
    input  wire logic       globalLatchTrigger,
    // status and control outputs
    output logic            irq,
    output logic            timerEvent,
    output logic            secondTick,
    output logic            counterLatch,
    output logic [7:0]      linkCaptureByte,
    output logic            fsErrorReportEnable,
    output logic            outOfSyncCountSelect
);

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    logic [7:0]  errCfg;
    logic [5:0]  status;
    logic [5:0]  mask;
    logic [5:0]  setVec;
    logic [5:0]  clearVec;
    logic [7:0]  linkShift;
    logic [2:0]  linkCount;
    logic        linkFull;
    logic        codeValidPrev;
    logic [31:0] secondCount;
    logic        ownSecond;
    logic [8:0]  frameCount;
    logic [8:0]  frameLimit;
    logic        frameWrap;
    logic        intervalTick;
    logic        manualPrev;
    logic        globalPrev;
    logic        manualEdge;
    logic        latchReq;
    logic [4:0]  zeroRun;
    logic [4:0]  zeroLimit;
    logic        zeroEvent;
    logic        bpvEvent;
    logic [1:0]  lcvInc;
    logic [16:0] lcvSum;
    logic [15:0] lcvRunning;
    logic [15:0] lcvLatched;
    accum_mode_t accumMode;
    wire logic   wrCfg;
    wire logic   wrStatus;
    wire logic   wrMask;

    // host write decodes
    assign wrCfg    = hostReq.wrEn && hostReq.addr == ADDR_ERR_CFG;
    assign wrStatus = hostReq.wrEn && hostReq.addr == ADDR_EVT_STATUS;
    assign wrMask   = hostReq.wrEn && hostReq.addr == ADDR_EVT_MASK;
    assign accumMode = errCfg[CFG_ACCUM_MODE] ? ACC_MANUAL : ACC_TIMED;

    // configuration register, all fields plain read/write
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            errCfg <= REG_RESET;
        end else if (wrCfg) begin
            errCfg <= hostReq.wrData;
        end
    end

    // mask keeps only the six live positions; upper bits unused
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            mask <= REG_RESET[5:0];
        end else if (wrMask) begin
            mask <= hostReq.wrData[5:0];
        end
    end

    // capture shifter for the facility data link, msb first
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            linkShift       <= REG_RESET;
            linkCount       <= 3'h0;
            linkCaptureByte <= REG_RESET;
        end else if (detectIn.linkBitValid) begin
            linkShift <= {linkShift[6:0], detectIn.linkBit};
            linkCount <= linkCount + 3'h1;
            if (linkCount == LINK_LAST_BIT) begin
                linkCaptureByte <= {linkShift[6:0], detectIn.linkBit};
            end
        end
    end
    assign linkFull = detectIn.linkBitValid && linkCount == LINK_LAST_BIT;

    // code-valid history for detect and clear edges
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            codeValidPrev <= 1'b0;
        end else begin
            codeValidPrev <= detectIn.codeValid;
        end
    end

    // event sources; the CI flags are gated by their alarm conditions
    always_comb begin
        setVec = '0;
        setVec[EVT_REMOTE_CI] = detectIn.remoteAlarmCi
            && detectIn.esfFraming && detectIn.remoteAlarmPresent;
        setVec[EVT_AIS_CI] = detectIn.aisCi && detectIn.aisPresent;
        setVec[EVT_FS_ALIGN]  = detectIn.fsAlignFound;
        setVec[EVT_LINK_FULL] = linkFull;
        setVec[EVT_CODE_CLR]  = codeValidPrev && !detectIn.codeValid;
        setVec[EVT_CODE_DET]  = !codeValidPrev && detectIn.codeValid;
    end
    assign clearVec = wrStatus ? hostReq.wrData[5:0] : 6'h00;

    // sticky flags, write one to clear; a new event beats the clear
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            status <= REG_RESET[5:0];
        end else begin
            status <= (status & ~clearVec) | setVec;
        end
    end

    // interrupt from any unmasked flag
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            irq <= 1'b0;
        end else begin
            irq <= |(status & mask);
        end
    end

    // own one-second timer from the system clock
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            secondCount <= 32'h0;
        end else if (ownSecond) begin
            secondCount <= 32'h0;
        end else begin
            secondCount <= secondCount + 32'h1;
        end
    end
    assign ownSecond = secondCount == 32'(SECOND_COUNT - 1);

    // short interval counted in frames: 336 for T1, 500 for E1
    assign frameLimit = lineIn.e1Mode ? FRAMES_E1_SHORT
                                      : FRAMES_T1_SHORT;
    assign frameWrap = lineIn.frameTick && frameCount == frameLimit - 9'h1;
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            frameCount <= 9'h0;
        end else if (frameWrap) begin
            frameCount <= 9'h0;
        end else if (lineIn.frameTick) begin
            frameCount <= frameCount + 9'h1;
        end
    end

    // interval tick: short frames period or the chosen one-second source
    always_comb begin
        if (errCfg[CFG_INTERVAL]) begin
            intervalTick = frameWrap;
        end else if (errCfg[CFG_SECOND_SRC]) begin
            intervalTick = firstPortSecond;
        end else begin
            intervalTick = ownSecond;
        end
    end

    // trigger histories for the manual edge detectors
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            manualPrev <= 1'b0;
            globalPrev <= 1'b0;
        end else begin
            manualPrev <= errCfg[CFG_MANUAL_TRIG];
            globalPrev <= globalLatchTrigger;
        end
    end

    // manual edge from per-port bit or global bit
    assign manualEdge = errCfg[CFG_MANUAL_SRC]
        ? (globalLatchTrigger && !globalPrev)
        : (errCfg[CFG_MANUAL_TRIG] && !manualPrev);

    // latch request by accumulation mode
    always_comb begin
        case (accumMode)
            ACC_TIMED:  latchReq = intervalTick;
            ACC_MANUAL: latchReq = manualEdge;
            default:    latchReq = 1'b0;
        endcase
    end

    // latch strobe lands one cycle after the request
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            counterLatch <= 1'b0;
            timerEvent   <= 1'b0;
            secondTick   <= 1'b0;
        end else begin
            counterLatch <= latchReq;
            timerEvent   <= intervalTick;
            secondTick   <= ownSecond;
        end
    end

    // counting options passed to the framing counters
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            fsErrorReportEnable  <= 1'b0;
            outOfSyncCountSelect <= 1'b0;
        end else begin
            fsErrorReportEnable  <= errCfg[CFG_FS_REPORT];
            outOfSyncCountSelect <= errCfg[CFG_OOS_SELECT];
        end
    end

    // zero-run length: 8 with B8ZS, 16 without
    assign zeroLimit = lineIn.b8zsEnable ? ZERO_RUN_B8ZS
                                         : ZERO_RUN_PLAIN;
    assign zeroEvent = errCfg[CFG_EXCESS_ZERO] && lineIn.bitStrobe
        && lineIn.rxZero && zeroRun == zeroLimit - 5'h1;

    // each complete run counts once, then the run restarts
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            zeroRun <= 5'h0;
        end else if (lineIn.bitStrobe) begin
            if (!lineIn.rxZero || zeroRun == zeroLimit - 5'h1) begin
                zeroRun <= 5'h0;
            end else begin
                zeroRun <= zeroRun + 5'h1;
            end
        end
    end

    // codewords are legal substitutions when B8ZS is on
    assign bpvEvent = lineIn.bitStrobe && lineIn.bipolarViolation
        && !(lineIn.b8zsEnable && lineIn.b8zsCodeword);
    assign lcvInc = {1'b0, bpvEvent} + {1'b0, zeroEvent};
    assign lcvSum = {1'b0, lcvRunning} + {15'h0, lcvInc};

    // running counter never gated by sync loss; saturates at full scale
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            lcvRunning <= 16'h0;
        end else if (counterLatch) begin
            lcvRunning <= {14'h0, lcvInc};
        end else if (lcvSum[16]) begin
            lcvRunning <= COUNT_MAX;
        end else begin
            lcvRunning <= lcvSum[15:0];
        end
    end

    // both bytes copied together so a split read stays coherent
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            lcvLatched <= 16'h0;
        end else if (counterLatch) begin
            lcvLatched <= lcvRunning;
        end
    end

    // registered read data, unmapped offsets read zero
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rdData <= REG_RESET;
        end else if (hostReq.rdEn) begin
            case (hostReq.addr)
                ADDR_LCV_HIGH:   rdData <= lcvLatched[15:8];
                ADDR_LCV_LOW:    rdData <= lcvLatched[7:0];
                ADDR_ERR_CFG:    rdData <= errCfg;
                ADDR_EVT_STATUS: rdData <= {2'b00, status};
                ADDR_EVT_MASK:   rdData <= {2'b00, mask};
                default:         rdData <= REG_RESET;
            endcase
        end
    end

    // checks next to the logic
    sequence manualTrig;
        accumMode == ACC_MANUAL && !errCfg[CFG_MANUAL_SRC]
            && errCfg[CFG_MANUAL_TRIG] && !manualPrev;
    endsequence
    sequence globalTrig;
        accumMode == ACC_MANUAL && errCfg[CFG_MANUAL_SRC]
            && globalLatchTrigger && !globalPrev;
    endsequence

    remote_ci_gate_a: assert property (
        $rose(status[EVT_REMOTE_CI]) |-> $past(detectIn.esfFraming)
            && $past(detectIn.remoteAlarmPresent))
        else $error("remote alarm CI flag set without ESF alarm");

    ais_ci_gate_a: assert property (
        $rose(status[EVT_AIS_CI]) |-> $past(detectIn.aisPresent))
        else $error("AIS CI flag set without AIS condition");

    link_full_a: assert property (
        linkFull |=> status[EVT_LINK_FULL]
            && linkCaptureByte == $past(
                {linkShift[6:0], detectIn.linkBit}))
        else $error("link full flag or byte missing");

    code_edges_a: assert property (
        codeValidPrev && !detectIn.codeValid |=> status[EVT_CODE_CLR])
        else $error("code cleared flag not set");

    code_detect_a: assert property (
        !codeValidPrev && detectIn.codeValid |=> status[EVT_CODE_DET])
        else $error("code detected flag not set");

    status_reserved_a: assert property (
        hostReq.rdEn && hostReq.addr == ADDR_EVT_STATUS
            |=> rdData[7:6] == 2'b00 && rdData[5:0] == $past(status))
        else $error("status read mismatch");

    irq_mask_a: assert property (
        |(status & mask) |=> irq)
        else $error("unmasked flag gave no interrupt");

    irq_blocked_a: assert property (
        (status & mask) == 6'h00 |=> !irq)
        else $error("interrupt without unmasked flag");

    second_source_a: assert property (
        accumMode == ACC_TIMED && !errCfg[CFG_INTERVAL]
            && errCfg[CFG_SECOND_SRC] && firstPortSecond
            |=> counterLatch)
        else $error("first port second did not latch");

    manual_latch_a: assert property (
        manualTrig |=> counterLatch ##1 lcvLatched == $past(lcvRunning))
        else $error("manual trigger did not latch counts");

    global_latch_a: assert property (
        globalTrig |=> counterLatch)
        else $error("global trigger did not latch counts");

    short_interval_a: assert property (
        errCfg[CFG_INTERVAL] && frameWrap |=> timerEvent)
        else $error("short interval gave no timer event");

    lcv_counts_a: assert property (
        bpvEvent && !counterLatch && lcvRunning < 16'hFFF0
            |=> lcvRunning > $past(lcvRunning))
        else $error("violation not counted");

    lcv_hold_a: assert property (
        !counterLatch |=> $stable(lcvLatched))
        else $error("latched count changed without latch");

endmodule : t1_rx_perf_monitor
`default_nettype wire

// ===== bench/testbench.sv
// self-checking bench for the receive performance monitor
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) begin nTests++; if ((got) !== (exp)) begin errTotal++; \
    $display("BAD t=%0t got %h exp %h", $time, got, exp); end end
module testbench;
    import t1_rx_perf_pkg::*;
    // short second keeps timed runs brief; ceiling covers all scenarios
    localparam int SEC_SIM    = 100;
    localparam int TIME_LIMIT = 40000;
    logic       clk;
    logic       reset;
    host_req_t  hostReq;
    logic [7:0] rdData;
    detect_in_t detectIn;
    line_in_t   lineIn;
    logic       firstPortSecond;
    logic       globalLatchTrigger;
    logic       irq;
    logic       timerEvent;
    logic       secondTick;
    logic       counterLatch;
    logic [7:0] linkCaptureByte;
    logic       fsErrorReportEnable;
    logic       outOfSyncCountSelect;
    int         errTotal;
    int         nTests;
    int         cycles;
    int         tevCnt;
    int         stCnt;
    int         latCnt;

    t1_rx_perf_monitor #(.SECOND_COUNT(SEC_SIM)) u_dut (
        .clk(clk), .reset(reset), .hostReq(hostReq), .rdData(rdData),
        .detectIn(detectIn), .lineIn(lineIn),
        .firstPortSecond(firstPortSecond),
        .globalLatchTrigger(globalLatchTrigger), .irq(irq),
        .timerEvent(timerEvent), .secondTick(secondTick),
        .counterLatch(counterLatch), .linkCaptureByte(linkCaptureByte),
        .fsErrorReportEnable(fsErrorReportEnable),
        .outOfSyncCountSelect(outOfSyncCountSelect)
    );

    // 50 MHz clock
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // cycle ceiling and timer event tally
    always @(posedge clk) begin
        cycles++;
        if (timerEvent === 1'b1) tevCnt++;
        if (secondTick === 1'b1) stCnt++;
        if (counterLatch === 1'b1) latCnt++;
        if (cycles >= TIME_LIMIT) begin
            errTotal++;
            $display("BAD t=%0t got %h exp %h", $time, cycles, TIME_LIMIT);
            wrapUp();
        end
    end

    task automatic wrapUp;
        $display("errors %0d checks %0d", errTotal, nTests);
        if (errTotal == 0 && nTests > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : wrapUp

    // one write strobe, returns just after the taking edge has landed
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        hostReq <= '{addr: a, wrData: d, wrEn: 1'b1, rdEn: 1'b0};
        @(posedge clk);
        hostReq.wrEn <= 1'b0;
        #1;
    endtask : wr

    // read and compare; data is registered at the taking edge
    task automatic chkReg(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        hostReq <= '{addr: a, wrData: 8'h00, wrEn: 1'b0, rdEn: 1'b1};
        @(posedge clk);
        hostReq.rdEn <= 1'b0;
        #1;
        `CHK(rdData, exp)
    endtask : chkReg

    // pulse inputs last one cycle, level inputs stay as given
    task automatic detPulse(input detect_in_t d);
        @(posedge clk);
        detectIn <= d;
        @(posedge clk);
        detectIn.remoteAlarmCi <= 1'b0;
        detectIn.aisCi <= 1'b0;
        detectIn.fsAlignFound <= 1'b0;
        detectIn.linkBitValid <= 1'b0;
    endtask : detPulse

    task automatic bitIn(input logic z, input logic bpv, input logic cw);
        @(posedge clk);
        lineIn.bitStrobe <= 1'b1;
        lineIn.rxZero <= z;
        lineIn.bipolarViolation <= bpv;
        lineIn.b8zsCodeword <= cw;
        @(posedge clk);
        lineIn.bitStrobe <= 1'b0;
    endtask : bitIn

    task automatic frames(input int n);
        repeat (n) begin
            @(posedge clk);
            lineIn.frameTick <= 1'b1;
            @(posedge clk);
            lineIn.frameTick <= 1'b0;
        end
        repeat (3) @(posedge clk);
    endtask : frames

    // reset values, unmapped place, config read back
    task automatic tResetRegs;
        logic [7:0] addrs [6] = '{8'h50, 8'h51, 8'h86, 8'h96, 8'hA6, 8'h7F};
        wr(8'h7F, 8'hFF);
        foreach (addrs[i]) chkReg(addrs[i], REG_RESET);
        wr(ADDR_ERR_CFG, 8'h5A);
        chkReg(ADDR_ERR_CFG, 8'h5A);
        wr(ADDR_ERR_CFG, 8'h00);
    endtask : tResetRegs

    // alarm flags: gating, masking, interrupt and clearing
    task automatic tAlarm;
        detect_in_t d;
        wr(ADDR_EVT_MASK, 8'hFF);
        chkReg(ADDR_EVT_MASK, 8'h3F);
        d = '0;
        d.remoteAlarmCi = 1'b1;
        d.remoteAlarmPresent = 1'b1;
        detPulse(d);
        d.remoteAlarmPresent = 1'b0;
        d.esfFraming = 1'b1;
        detPulse(d);
        chkReg(ADDR_EVT_STATUS, 8'h00);
        d.remoteAlarmPresent = 1'b1;
        detPulse(d);
        chkReg(ADDR_EVT_STATUS, 8'h20);
        `CHK(irq, 1'b1)
        wr(ADDR_EVT_STATUS, 8'hFF);
        chkReg(ADDR_EVT_STATUS, 8'h00);
        `CHK(irq, 1'b0)
        d = '0;
        d.aisCi = 1'b1;
        detPulse(d);
        chkReg(ADDR_EVT_STATUS, 8'h00);
        d.aisPresent = 1'b1;
        detPulse(d);
        chkReg(ADDR_EVT_STATUS, 8'h10);
        wr(ADDR_EVT_STATUS, 8'h10);
        wr(ADDR_EVT_MASK, 8'h00);
        d = '0;
        d.fsAlignFound = 1'b1;
        detPulse(d);
        chkReg(ADDR_EVT_STATUS, 8'h08);
        `CHK(irq, 1'b0)
        wr(ADDR_EVT_MASK, 8'h08);
        repeat (2) @(posedge clk);
        `CHK(irq, 1'b1)
        wr(ADDR_EVT_STATUS, 8'hFF);
    endtask : tAlarm

    // link byte assembly and bit-oriented code detect/clear
    task automatic tLinkCode;
        detect_in_t d;
        logic [7:0] v;
        v = 8'hA5;
        for (int i = 7; i >= 0; i--) begin
            d = '0;
            d.linkBitValid = 1'b1;
            d.linkBit = v[i];
            detPulse(d);
            if (i == 1) chkReg(ADDR_EVT_STATUS, 8'h00);
        end
        chkReg(ADDR_EVT_STATUS, 8'h04);
        `CHK(linkCaptureByte, v)
        wr(ADDR_EVT_STATUS, 8'hFF);
        @(posedge clk);
        detectIn.codeValid <= 1'b1;
        chkReg(ADDR_EVT_STATUS, 8'h01);
        wr(ADDR_EVT_STATUS, 8'hFF);
        chkReg(ADDR_EVT_STATUS, 8'h00);
        @(posedge clk);
        detectIn.codeValid <= 1'b0;
        chkReg(ADDR_EVT_STATUS, 8'h02);
        wr(ADDR_EVT_STATUS, 8'hFF);
    endtask : tLinkCode

    // line-code counting, manual and global latching, byte pairing
    task automatic tLineCounter;
        wr(ADDR_ERR_CFG, 8'h08);
        wr(ADDR_ERR_CFG, 8'h28);
        wr(ADDR_ERR_CFG, 8'h09);
        @(posedge clk);
        lineIn.b8zsEnable <= 1'b1;
        lineIn.receiveSyncLost <= 1'b1;
        repeat (3) bitIn(1'b0, 1'b1, 1'b0);
        bitIn(1'b0, 1'b1, 1'b1);
        repeat (8) bitIn(1'b1, 1'b0, 1'b0);
        @(posedge clk);
        lineIn.b8zsEnable <= 1'b0;
        bitIn(1'b0, 1'b1, 1'b0);
        repeat (16) bitIn(1'b1, 1'b0, 1'b0);
        wr(ADDR_ERR_CFG, 8'h29);
        // host must let the manual update settle before reading
        repeat (MANUAL_WAIT_CYCLES) @(posedge clk);
        chkReg(ADDR_LCV_HIGH, 8'h00);
        chkReg(ADDR_LCV_LOW, 8'h06);
        // latched copy must not move while running counts grow
        repeat (258) bitIn(1'b0, 1'b1, 1'b0);
        chkReg(ADDR_LCV_LOW, 8'h06);
        wr(ADDR_ERR_CFG, 8'h48);
        wr(ADDR_ERR_CFG, 8'h68);
        repeat (4) @(posedge clk);
        chkReg(ADDR_LCV_LOW, 8'h06);
        @(posedge clk);
        globalLatchTrigger <= 1'b1;
        repeat (MANUAL_WAIT_CYCLES) @(posedge clk);
        chkReg(ADDR_LCV_HIGH, 8'h01);
        chkReg(ADDR_LCV_LOW, 8'h02);
        globalLatchTrigger <= 1'b0;
    endtask : tLineCounter

    // timed update intervals and their sources
    task automatic tTimed;
        int base;
        int sBase;
        int lBase;
        wr(ADDR_ERR_CFG, 8'h16);
        // option outputs follow the register one cycle later
        repeat (2) @(posedge clk);
        #1;
        `CHK(fsErrorReportEnable, 1'b1)
        `CHK(outOfSyncCountSelect, 1'b1)
        base = tevCnt;
        frames(1008);
        `CHK(tevCnt - base, 3)
        @(posedge clk);
        lineIn.e1Mode <= 1'b1;
        base = tevCnt;
        frames(1500);
        `CHK(tevCnt - base, 3)
        wr(ADDR_ERR_CFG, 8'h04);
        repeat (2) @(posedge clk);
        #1;
        `CHK(fsErrorReportEnable, 1'b1)
        `CHK(outOfSyncCountSelect, 1'b0)
        base = tevCnt;
        sBase = stCnt;
        lBase = latCnt;
        repeat (3 * SEC_SIM) @(posedge clk);
        #1;
        `CHK(tevCnt - base, 3)
        `CHK(stCnt - sBase, 3)
        `CHK(latCnt - lBase, 3)
        wr(ADDR_ERR_CFG, 8'h80);
        // let a tick launched under the old setting drain first
        repeat (2) @(posedge clk);
        #1;
        base = tevCnt;
        repeat (2) begin
            @(posedge clk);
            firstPortSecond <= 1'b1;
            @(posedge clk);
            firstPortSecond <= 1'b0;
            repeat (60) @(posedge clk);
        end
        `CHK(tevCnt - base, 2)
    endtask : tTimed

    // main sequence
    initial begin
        errTotal = 0;
        nTests = 0;
        cycles = 0;
        tevCnt = 0;
        reset <= 1'b1;
        hostReq <= '0;
        detectIn <= '0;
        lineIn <= '0;
        firstPortSecond <= 1'b0;
        globalLatchTrigger <= 1'b0;
        repeat (12) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        tResetRegs();
        tAlarm();
        tLinkCode();
        tLineCounter();
        tTimed();
        wrapUp();
    end
endmodule : testbench
`undef CHK
`default_nettype wire
